/* File: core/aacs_ctrl_status.v */
/*
  Control and status register group of the class-D amplifier:
  sticky error flags, filter and unmute control, serial format,
  shutdown and modulation control, per-channel soft mute.
  Assumes clk is the audio master clock, the control port decoder
  gives one-cycle write and read strobes on clk, and frame and bit
  clocks arrive from pins.
*/
`timescale 1ns/1ps
`include "aacs_regs.vh"
module aacs_ctrl_status #(
  parameter CW = 16,
  parameter LR_TOL = 16'h0004,
  parameter LR_TIMEOUT = 16'h1000
) (
  input wire clk,
  input wire rstn,
  input wire [7:0] reg_addr,
  input wire reg_wr,
  input wire [7:0] reg_wdata,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  input wire lrclk_pin,
  input wire bclk_pin,
  input wire pll_unlock,
  input wire clip_event,
  input wire fault_event,
  input wire [1:0] volume_slew,
  input wire [3:0] shutdown_group,
  input wire address_or_fault_pin_in,
  output reg address_or_fault_pin_out,
  output reg address_or_fault_pin_oe_n,
  output reg address_select,
  input wire speaker_fault_output,
  output reg dc_block_enable,
  output reg [1:0] deemph_sel,
  output reg [1:0] rx_family,
  output reg [1:0] rx_word_len,
  output reg rx_format_valid,
  output reg all_channel_shutdown,
  output reg ternary_mod,
  output reg [2:0] channel_half_duty,
  output reg [3:0] pwm_channel_run,
  output reg audio_muted,
  output reg unmute_ramp_active
);

  // Stored registers
  reg [7:0] error_flags; // Sticky error flags
  reg [7:0] system_control_one; // Filter, unmute, de-emphasis
  reg [7:0] serial_format_select; // Serial format code
  reg [7:0] system_control_two; // Shutdown, modulation, pin dir
  reg [7:0] channel_soft_mute; // Per channel soft mute

  // Pin synchronisers
  reg lr_s1, lr_s2, lr_s3; // Frame clock stages
  reg bc_s1, bc_s2, bc_s3; // Bit clock stages
  reg ad_s1, ad_s2; // Address pin stages
  wire lr_rise; // Frame start edge
  wire bclk_rise; // Bit clock edge

  // Meter results
  wire frame_tick;
  wire [CW-1:0] clk_count;
  wire [CW-1:0] bclk_count;

  // Detection state
  reg [CW-1:0] prev_clk; // Last frame length
  reg [CW-1:0] prev_bclk; // Last bit clock count
  reg [1:0] frames_seen; // Frames since start, saturating
  reg [CW-1:0] sync_cnt; // Internal frame sync down count
  reg [CW-1:0] idle_cnt; // Clocks without frame edge
  reg clk_fault_live; // Clock error still present
  reg was_live; // Delayed copy for recovery edge
  reg was_shut; // Delayed shutdown for exit edge
  reg [11:0] ramp_left; // Soft unmute steps left

  // Per frame detection pulses
  reg det_mclk, det_sclk, det_lrclk, det_slip;
  reg [CW-1:0] diff; // Frame length difference
  reg [7:0] err_set; // Hardware set vector
  reg [7:0] next_err; // Next flag value

  // Ramp length for a slew code
  function [11:0] ramp_steps;
    input [1:0] code;
    begin
      case (code)
        2'h0: ramp_steps = `AACS_RAMP_0;
        2'h1: ramp_steps = `AACS_RAMP_1;
        2'h2: ramp_steps = `AACS_RAMP_2;
        default: ramp_steps = `AACS_RAMP_3;
      endcase
    end
  endfunction

  // Write strobe decode for one register
  function wr_hit;
    input [7:0] addr;
    input [7:0] target;
    input wr;
    begin
      wr_hit = wr && (addr == target);
    end
  endfunction

  assign lr_rise = lr_s2 && !lr_s3;
  assign bclk_rise = bc_s2 && !bc_s3;

  // Two stage pin synchronisers and edge history
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      lr_s1 <= 1'b0;
      lr_s2 <= 1'b0;
      lr_s3 <= 1'b0;
      bc_s1 <= 1'b0;
      bc_s2 <= 1'b0;
      bc_s3 <= 1'b0;
      ad_s1 <= 1'b0;
      ad_s2 <= 1'b0;
    end
    else
    begin
      lr_s1 <= lrclk_pin;
      lr_s2 <= lr_s1;
      lr_s3 <= lr_s2;
      bc_s1 <= bclk_pin;
      bc_s2 <= bc_s1;
      bc_s3 <= bc_s2;
      ad_s1 <= address_or_fault_pin_in;
      ad_s2 <= ad_s1;
    end
  end

  // Frame length and bit clock meter
  aacs_frame_meter #(
    .CW(CW)
  ) u_meter (
    .clk(clk),
    .rstn(rstn),
    .lr_rise(lr_rise),
    .bclk_rise(bclk_rise),
    .frame_tick(frame_tick),
    .clk_count(clk_count),
    .bclk_count(bclk_count)
  );

  // Per frame comparisons against the previous frame
  always @*
  begin
    diff = (clk_count > prev_clk) ? clk_count - prev_clk : prev_clk - clk_count;
    det_mclk = 1'b0;
    det_sclk = 1'b0;
    det_lrclk = 1'b0;
    det_slip = 1'b0;
    if (frame_tick && frames_seen == 2'h3)
    begin
      // Small shift: master clocks per frame varied
      det_mclk = (diff != {CW{1'b0}}) && (diff <= LR_TOL); // RL2
      // Bit clocks per frame varied
      det_sclk = (bclk_count != prev_bclk); // RL3
      // Large shift: frame clock frequency changed
      det_lrclk = (diff > LR_TOL); // RL4
      // Frame edge off the internal sync point
      det_slip = (diff == {CW{1'b0}}) &&
        (sync_cnt != {{(CW-1){1'b0}}, 1'b1}); // RL5
    end
    // Frame clock stopped counts as frequency change
    if (idle_cnt == LR_TIMEOUT)
      det_lrclk = 1'b1; // RL4
  end

  // Hardware set vector for sticky flags
  always @*
  begin
    err_set = 8'h00;
    err_set[`AACS_ERR_MCLK] = det_mclk;
    err_set[`AACS_ERR_PLL] = pll_unlock; // RL6
    err_set[`AACS_ERR_SCLK] = det_sclk;
    err_set[`AACS_ERR_LRCLK] = det_lrclk;
    err_set[`AACS_ERR_SLIP] = det_slip;
    err_set[`AACS_ERR_CLIP] = clip_event; // RL6
    err_set[`AACS_ERR_FAULT] = fault_event; // RL6
    // Software write of zero clears, set wins
    next_err = error_flags;
    if (wr_hit(reg_addr, `AACS_ADDR_ERR, reg_wr))
      next_err = error_flags & reg_wdata; // RL1
    next_err = (next_err | err_set) & `AACS_MASK_ERR; // RL1
  end

  // Frame tracking: history, internal sync, idle watch
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      prev_clk <= {CW{1'b0}};
      prev_bclk <= {CW{1'b0}};
      frames_seen <= 2'h0;
      sync_cnt <= {CW{1'b0}};
      idle_cnt <= {CW{1'b0}};
    end
    else
    begin
      if (frame_tick)
      begin
        prev_clk <= clk_count;
        prev_bclk <= bclk_count;
        if (frames_seen != 2'h3)
          frames_seen <= frames_seen + 2'h1;
      end
      // Free running sync, resynced on slip or frame rate change;
      // small length changes let it run on so drift shows as slip
      if (frame_tick && (det_slip || sync_cnt == {CW{1'b0}} || det_lrclk))
        sync_cnt <= clk_count; // RL5
      else if (sync_cnt <= {{(CW-1){1'b0}}, 1'b1})
        sync_cnt <= prev_clk;
      else
        sync_cnt <= sync_cnt - {{(CW-1){1'b0}}, 1'b1};
      // Idle count, held after timeout
      if (lr_rise)
        idle_cnt <= {CW{1'b0}};
      else if (idle_cnt != LR_TIMEOUT)
        idle_cnt <= idle_cnt + {{(CW-1){1'b0}}, 1'b1};
    end
  end

  // Register writes, reserved bits dropped
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      error_flags <= 8'h00;
      system_control_one <= `AACS_RST_SC1; // RL7
      serial_format_select <= `AACS_RST_FMT; // RL12
      system_control_two <= `AACS_RST_SC2; // RL13
      channel_soft_mute <= `AACS_RST_MUTE;
    end
    else
    begin
      error_flags <= next_err;
      if (wr_hit(reg_addr, `AACS_ADDR_SC1, reg_wr))
        system_control_one <= reg_wdata & `AACS_MASK_SC1; // RL19
      if (wr_hit(reg_addr, `AACS_ADDR_FMT, reg_wr))
        serial_format_select <= reg_wdata & `AACS_MASK_FMT; // RL19
      if (wr_hit(reg_addr, `AACS_ADDR_SC2, reg_wr))
        system_control_two <= reg_wdata & `AACS_MASK_SC2; // RL19
      if (wr_hit(reg_addr, `AACS_ADDR_MUTE, reg_wr))
        channel_soft_mute <= reg_wdata & `AACS_MASK_MUTE; // RL19
    end
  end

  // Registered read data, unmapped reads zero
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      reg_rdata <= 8'h00;
    else if (reg_rd)
    begin
      case (reg_addr)
        `AACS_ADDR_ERR: reg_rdata <= error_flags;
        `AACS_ADDR_SC1: reg_rdata <= system_control_one;
        `AACS_ADDR_FMT: reg_rdata <= serial_format_select;
        `AACS_ADDR_SC2: reg_rdata <= system_control_two;
        `AACS_ADDR_MUTE: reg_rdata <= channel_soft_mute;
        default: reg_rdata <= 8'h00;
      endcase
    end
  end

  // Decoded control outputs
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      dc_block_enable <= 1'b1;
      deemph_sel <= 2'h0;
      rx_family <= `AACS_FAM_I2S;
      rx_word_len <= 2'h2;
      rx_format_valid <= 1'b1;
      all_channel_shutdown <= 1'b1;
      ternary_mod <= 1'b0;
      channel_half_duty <= 3'h0;
    end
    else
    begin
      dc_block_enable <= system_control_one[`AACS_SC1_DCBLK]; // RL7
      deemph_sel <= system_control_one[1:0]; // RL10
      // Codes step word length fastest, then family
      rx_format_valid <= serial_format_select[3:0] <= `AACS_FMT_LAST; // RL11
      case (serial_format_select[3:0])
        4'h0, 4'h1, 4'h2: rx_family <= `AACS_FAM_RJ; // RL11
        4'h3, 4'h4, 4'h5: rx_family <= `AACS_FAM_I2S; // RL11
        4'h6, 4'h7, 4'h8: rx_family <= `AACS_FAM_LJ; // RL11
        default: rx_family <= rx_family;
      endcase
      case (serial_format_select[3:0])
        4'h0, 4'h3, 4'h6: rx_word_len <= 2'h0;
        4'h1, 4'h4, 4'h7: rx_word_len <= 2'h1;
        4'h2, 4'h5, 4'h8: rx_word_len <= 2'h2;
        default: rx_word_len <= rx_word_len;
      endcase
      all_channel_shutdown <= system_control_two[`AACS_SC2_SHUT]; // RL13
      ternary_mod <= system_control_two[`AACS_SC2_TERN]; // RL14
      channel_half_duty <= channel_soft_mute[2:0]; // RL16
    end
  end

  // Shared address/fault pin
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      address_or_fault_pin_out <= 1'b0;
      address_or_fault_pin_oe_n <= 1'b1;
      address_select <= 1'b0;
    end
    else
    begin
      // Drive fault when output, else sample address
      address_or_fault_pin_oe_n <= !system_control_two[`AACS_SC2_FOUT]; // RL15
      address_or_fault_pin_out <= speaker_fault_output; // RL15
      if (!system_control_two[`AACS_SC2_FOUT])
        address_select <= ad_s2; // RL15
    end
  end

  // Clock fault level, unmute and channel start
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      clk_fault_live <= 1'b0;
      was_live <= 1'b0;
      was_shut <= 1'b1;
      ramp_left <= 12'h000;
      pwm_channel_run <= 4'h0;
      audio_muted <= 1'b1;
      unmute_ramp_active <= 1'b0;
    end
    else
    begin
      // Live while clock errors keep showing
      if (det_mclk || det_sclk || det_lrclk || det_slip)
        clk_fault_live <= 1'b1;
      else if (frame_tick)
        clk_fault_live <= 1'b0;
      was_live <= clk_fault_live;
      was_shut <= all_channel_shutdown;
      // Hard unmute skips ramp; soft one ramps
      if (all_channel_shutdown || clk_fault_live)
        ramp_left <= 12'h000;
      else if ((was_live || was_shut) &&
        !system_control_one[`AACS_SC1_HARD]) // RL8 RL9
        ramp_left <= ramp_steps(volume_slew); // RL17
      else if (frame_tick && ramp_left != 12'h000)
        ramp_left <= ramp_left - 12'h001; // RL17
      // Group channels stay stopped after exit
      if (all_channel_shutdown)
        pwm_channel_run <= 4'h0;
      else if (was_shut)
        pwm_channel_run <= ~shutdown_group; // RL18
      audio_muted <= all_channel_shutdown || clk_fault_live; // RL13
      unmute_ramp_active <= ramp_left != 12'h000;
    end
  end

endmodule // aacs_ctrl_status

/* File: core/aacs_frame_meter.v */
/*
  Frame meter: counts system clocks and bit clock edges per frame.
  Assumes edge pulses are already synchronised to clk.
*/
`timescale 1ns/1ps
module aacs_frame_meter #(
  parameter CW = 16
) (
  input wire clk,
  input wire rstn,
  input wire lr_rise,
  input wire bclk_rise,
  output reg frame_tick,
  output reg [CW-1:0] clk_count,
  output reg [CW-1:0] bclk_count
);

  reg [CW-1:0] cnt; // Clocks since last frame start
  reg [CW-1:0] bcnt; // Bit clocks since last frame start
  wire cnt_full; // Saturation guards
  wire bcnt_full;

  assign cnt_full = &cnt;
  assign bcnt_full = &bcnt;

  // Count and latch per frame
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      cnt <= {CW{1'b0}};
      bcnt <= {CW{1'b0}};
      frame_tick <= 1'b0;
      clk_count <= {CW{1'b0}};
      bclk_count <= {CW{1'b0}};
    end
    else
    begin
      frame_tick <= lr_rise;
      if (lr_rise)
      begin
        // Latch totals, restart counts
        clk_count <= cnt_full ? cnt : cnt + {{(CW-1){1'b0}}, 1'b1};
        bclk_count <= (bclk_rise && !bcnt_full) ?
          bcnt + {{(CW-1){1'b0}}, 1'b1} : bcnt;
        cnt <= {CW{1'b0}};
        bcnt <= {CW{1'b0}};
      end
      else
      begin
        // Saturating counts inside frame
        if (!cnt_full)
          cnt <= cnt + {{(CW-1){1'b0}}, 1'b1};
        if (bclk_rise && !bcnt_full)
          bcnt <= bcnt + {{(CW-1){1'b0}}, 1'b1};
      end
    end
  end

endmodule // aacs_frame_meter

/* File: core/aacs_regs.vh */
/*
  Register offsets, field positions, reset values and masks of the
  amplifier control and status register group.
  Assumes it is included by the design modules by its bare name.
*/
// Notes on behaviour
// RL1: Error flags sticky; software clears writing zeros
// RL2: Master clock count per frame changes sets bit7; code sets it only for changes up to LR_TOL, larger ones set bit4
// RL3: Bit clock count per frame changes sets bit5
// RL4: Frame clock frequency change sets bit4
// RL5: Frame clock phase drift sets bit3
// RL6: Bit6 lock, bit2 clip, bit1 fault, bit0 zero
// RL7: Control one bit7 enables dc blocking, default on
// RL8: Control one bit5 picks soft or hard unmute
// RL9: Same unmute style on leaving all-channel shutdown
// RL10: Control one bits1-0 select de-emphasis curve
// RL11: Format low nibble picks nine formats, rest reserved
// RL12: Reset format is I2S 24-bit, code five
// RL13: Control two bit6 set means all-channel shutdown
// RL14: Control two bit3 selects ternary modulation
// RL15: Control two bit1 sets address/fault pin direction
// RL16: Soft mute bits force channel 50 percent duty
// RL17: Soft unmute ramp follows volume slew step count
// RL18: Shutdown group channels stay stopped after exit
// RL19: Reserved bits read zero, writes ignored
`ifndef AACS_REGS_VH
`define AACS_REGS_VH

// Register offsets
`define AACS_ADDR_ERR 8'h02
`define AACS_ADDR_SC1 8'h03
`define AACS_ADDR_FMT 8'h04
`define AACS_ADDR_SC2 8'h05
`define AACS_ADDR_MUTE 8'h06

// Writable bit masks, reserved bits outside
`define AACS_MASK_ERR 8'hFE
`define AACS_MASK_SC1 8'hA3
`define AACS_MASK_FMT 8'h0F
`define AACS_MASK_SC2 8'h4A
`define AACS_MASK_MUTE 8'h07

// Reset values
`define AACS_RST_SC1 8'h80
`define AACS_RST_FMT 8'h05
`define AACS_RST_SC2 8'h40
`define AACS_RST_MUTE 8'h00

// Error flag bit positions
`define AACS_ERR_MCLK 7
`define AACS_ERR_PLL 6
`define AACS_ERR_SCLK 5
`define AACS_ERR_LRCLK 4
`define AACS_ERR_SLIP 3
`define AACS_ERR_CLIP 2
`define AACS_ERR_FAULT 1

// Control field positions
`define AACS_SC1_DCBLK 7
`define AACS_SC1_HARD 5
`define AACS_SC2_SHUT 6
`define AACS_SC2_TERN 3
`define AACS_SC2_FOUT 1

// Format family codes
`define AACS_FAM_RJ 2'h0
`define AACS_FAM_I2S 2'h1
`define AACS_FAM_LJ 2'h2
`define AACS_FMT_LAST 4'h8

// Volume slew ramp lengths in steps
`define AACS_RAMP_0 12'h200
`define AACS_RAMP_1 12'h400
`define AACS_RAMP_2 12'h800
`define AACS_RAMP_3 12'h100

`endif

/* File: sim/aacs_ctrl_status_asserts.sv */
/* Checker on the top ports of the control register group.
   Assumes one clock and an active-low asynchronous reset. */
`timescale 1ns/1ps
module aacs_ctrl_status_asserts (
  input wire clk,
  input wire rstn,
  input wire [7:0] reg_addr,
  input wire reg_wr,
  input wire [7:0] reg_wdata,
  input wire [3:0] shutdown_group,
  input wire address_or_fault_pin_oe_n,
  input wire dc_block_enable,
  input wire [1:0] deemph_sel,
  input wire rx_format_valid,
  input wire all_channel_shutdown,
  input wire ternary_mod,
  input wire [2:0] channel_half_duty,
  input wire [3:0] pwm_channel_run
);
  // Write strobes per control register
  wire w3 = reg_wr && reg_addr == 8'h03;
  wire w4 = reg_wr && reg_addr == 8'h04;
  wire w5 = reg_wr && reg_addr == 8'h05;
  wire w6 = reg_wr && reg_addr == 8'h06;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  dc_block_a:
    assert property (w3 |-> ##2 dc_block_enable == $past(reg_wdata[7], 2))
      else $error("dc block enable wrong");
  deemph_sel_a:
    assert property (w3 |=> ##1 deemph_sel == $past(reg_wdata[1:0], 2))
      else $error("de-emphasis select wrong");
  format_valid_a:
    assert property (w4 |-> ##2 rx_format_valid == ($past(reg_wdata[3:0], 2) <= 4'h8))
      else $error("format valid wrong");
  shutdown_follow_a:
    assert property (w5 |-> ##2 all_channel_shutdown == $past(reg_wdata[6], 2))
      else $error("shutdown state wrong");
  ternary_mod_a:
    assert property (w5 |-> ##2 ternary_mod == $past(reg_wdata[3], 2))
      else $error("ternary select wrong");
  pin_dir_a:
    assert property (w5 |-> ##2 address_or_fault_pin_oe_n != $past(reg_wdata[1], 2))
      else $error("pin direction wrong");
  soft_mute_a:
    assert property (w6 |-> ##2 channel_half_duty == $past(reg_wdata[2:0], 2))
      else $error("soft mute wrong");
  group_stop_a:
    assert property ($fell(all_channel_shutdown) |=> pwm_channel_run == ~$past(shutdown_group))
      else $error("shutdown group run wrong");
endmodule // aacs_ctrl_status_asserts
bind aacs_ctrl_status aacs_ctrl_status_asserts i_chk (.clk(clk), .rstn(rstn),
  .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
  .shutdown_group(shutdown_group), .address_or_fault_pin_oe_n(address_or_fault_pin_oe_n),
  .dc_block_enable(dc_block_enable), .deemph_sel(deemph_sel),
  .rx_format_valid(rx_format_valid), .all_channel_shutdown(all_channel_shutdown),
  .ternary_mod(ternary_mod), .channel_half_duty(channel_half_duty),
  .pwm_channel_run(pwm_channel_run));

/* File: sim/aacs_ctrl_status_tb.sv */
/* Bench: register traffic, frame clocks, event flags, unmute ramps.
   Assumes the host model and checker are compiled before it. */
`timescale 1ns/1ps
module aacs_ctrl_status_tb;
  reg clk, rstn, lrclk_pin, bclk_pin, pll_unlock, clip_event, fault_event;
  reg ext_addr, speaker_fault_output;
  reg [1:0] volume_slew;
  reg [3:0] shutdown_group;
  reg [7:0] d, r;
  integer miscompares, num_checks, i, a, n;
  wire [7:0] reg_addr, reg_wdata, reg_rdata;
  wire reg_wr, reg_rd, pin_out, oe_n, address_select, dc_block_enable, ramp_on;
  wire rx_format_valid, all_channel_shutdown, ternary_mod, audio_muted;
  wire [1:0] deemph_sel, rx_family, rx_word_len;
  wire [2:0] channel_half_duty;
  wire [3:0] pwm_channel_run;
  // Shared pin level: device drives it while enable is low
  wire pin_wire = oe_n ? ext_addr : pin_out;
  aacs_host i_host (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  aacs_ctrl_status #(.LR_TIMEOUT(16'h0040)) i_dut (.clk(clk), .rstn(rstn),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .lrclk_pin(lrclk_pin), .bclk_pin(bclk_pin),
    .pll_unlock(pll_unlock), .clip_event(clip_event), .fault_event(fault_event),
    .volume_slew(volume_slew), .shutdown_group(shutdown_group),
    .address_or_fault_pin_in(pin_wire), .address_or_fault_pin_out(pin_out),
    .address_or_fault_pin_oe_n(oe_n), .address_select(address_select),
    .speaker_fault_output(speaker_fault_output), .dc_block_enable(dc_block_enable),
    .deemph_sel(deemph_sel), .rx_family(rx_family), .rx_word_len(rx_word_len),
    .rx_format_valid(rx_format_valid), .all_channel_shutdown(all_channel_shutdown),
    .ternary_mod(ternary_mod), .channel_half_duty(channel_half_duty),
    .pwm_channel_run(pwm_channel_run), .audio_muted(audio_muted),
    .unmute_ramp_active(ramp_on));
  // Writable bits per address
  function [7:0] msk(input [7:0] ad);
    case (ad)
      8'h03: msk = 8'hA3;
      8'h04: msk = 8'h0F;
      8'h05: msk = 8'h4A;
      8'h06: msk = 8'h07;
      default: msk = 8'h00;
    endcase
  endfunction
  // Reset value per address
  function [7:0] rst(input [7:0] ad);
    rst = (ad == 8'h03) ? 8'h80 : (ad == 8'h04) ? 8'h05 : (ad == 8'h05) ? 8'h40 : 8'h00;
  endfunction
  // Family, word length and valid for a format code
  function [4:0] fmt_exp(input [3:0] c);
    reg [3:0] f, w;
  begin
    f = c / 4'h3;
    w = c % 4'h3;
    fmt_exp = (c > 4'h8) ? 5'h14 : {f[1:0], w[1:0], 1'b1};
  end
  endfunction
  // Ramp length in frames per slew code
  function integer steps(input [1:0] v);
    steps = (v == 2'h3) ? 256 : 512 << v;
  endfunction
  task chk(input [15:0] got, input [15:0] exp);
  begin
    num_checks = num_checks + 1;
    if (got !== exp)
    begin
      miscompares = miscompares + 1;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  end
  endtask
  task rdchk(input [7:0] ad, input [7:0] m, input [7:0] e);
  begin
    i_host.rd(ad, d);
    chk(d & m, e);
  end
  endtask
  // Frames of len clocks holding nb bit clock rises each
  task frames(input integer cnt, input integer len, input integer nb);
    integer f, k;
  begin
    for (f = 0; f < cnt; f = f + 1)
      for (k = 0; k < len; k = k + 1)
      begin
        @(negedge clk);
        lrclk_pin = (k < len / 2);
        bclk_pin = (k * 2 * nb / len) % 2;
      end
  end
  endtask
  // Steady frames, clear, then changed frames must raise flag m
  task clk_err(input integer len, input integer nb, input [7:0] m);
  begin
    frames(4, 32, 8);
    i_host.wr(8'h02, 8'h00);
    frames(4, len, nb);
    rdchk(8'h02, m, m);
  end
  endtask
  // Leave shutdown and count frames while the unmute ramp runs
  task ramp(input [1:0] vs, input hard);
    integer st;
  begin
    st = hard ? 0 : steps(vs);
    volume_slew = vs;
    shutdown_group = $urandom;
    i_host.wr(8'h05, 8'h40);
    i_host.wr(8'h03, hard ? 8'hA0 : 8'h80);
    frames(6, 16, 4);
    n = 0;
    fork
      frames(st + 10, 16, 4);
      begin
        i_host.wr(8'h05, 8'h00);
        repeat (3) @(negedge clk);
        while (ramp_on === 1'b1 && n < 4000)
        begin
          @(posedge lrclk_pin);
          n = n + 1;
        end
      end
    join
    // One frame of slack for tick alignment
    if (n + 1 == st || n == st + 1)
      n = st;
    chk(n[15:0], st[15:0]);
    chk({audio_muted, pwm_channel_run}, {1'b0, ~shutdown_group});
  end
  endtask
  task end_of_test;
  begin
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  end
  endtask
  // Clock, 100 ns period
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Watchdog against a hang
  initial
  begin
    #8000000;
    miscompares = miscompares + 1;
    end_of_test;
  end
  // Main sequence
  initial
  begin
    miscompares = 0;
    num_checks = 0;
    {rstn, lrclk_pin, bclk_pin, pll_unlock, clip_event, fault_event} = 6'h00;
    {ext_addr, speaker_fault_output, volume_slew, shutdown_group} = 8'h00;
    r = $urandom(65339);
    repeat (6) @(negedge clk);
    rstn = 1'b1;
    for (a = 0; a < 8; a = a + 1)
      rdchk(a[7:0], 8'hFF, rst(a[7:0]));
    chk({dc_block_enable, deemph_sel, rx_family, rx_word_len, rx_format_valid}, 8'h8D);
    chk({all_channel_shutdown, ternary_mod, channel_half_duty, oe_n}, 6'h21);
    $display("reset test done");
    for (i = 0; i < 4; i = i + 1)
    begin
      r = $urandom;
      @(negedge clk);
      {pll_unlock, clip_event, fault_event} = r[2:0];
      @(negedge clk);
      {pll_unlock, clip_event, fault_event} = 3'h0;
      rdchk(8'h02, 8'h46, {1'b0, r[2], 3'h0, r[1:0], 1'b0});
      i_host.wr(8'h02, 8'hFF);
      rdchk(8'h02, 8'h46, {1'b0, r[2], 3'h0, r[1:0], 1'b0});
      i_host.wr(8'h02, 8'h00);
      rdchk(8'h02, 8'h46, 8'h00);
    end
    $display("event flag test done");
    for (i = 0; i < 32; i = i + 1)
    begin
      // Error flags left out here: hardware may set them at any time
      a = (i % 8 == 2) ? 8 : ($urandom % 8 + 3) % 9;
      r = $urandom;
      i_host.wr(a[7:0], r);
      rdchk(a[7:0], 8'hFF, r & msk(a[7:0]));
    end
    for (i = 0; i < 16; i = i + 1)
    begin
      r = $urandom;
      i_host.wr(8'h03, {r[7:2], i[1:0]});
      i_host.wr(8'h04, {r[7:4], i[3:0]});
      rdchk(8'h04, 8'hFF, {4'h0, i[3:0]});
      chk({deemph_sel, rx_family, rx_word_len, rx_format_valid}, {i[1:0], fmt_exp(i[3:0])});
    end
    $display("register test done");
    clk_err(34, 8, 8'h80);
    clk_err(32, 6, 8'h20);
    clk_err(48, 8, 8'h10);
    frames(4, 32, 8);
    i_host.wr(8'h02, 8'h00);
    rdchk(8'h02, 8'hB0, 8'h00);
    repeat (90) @(negedge clk);
    rdchk(8'h02, 8'h10, 8'h10);
    $display("clock error test done");
    for (i = 0; i < 5; i = i + 1)
      ramp(i[1:0], i == 4);
    $display("unmute test done");
    ext_addr = $urandom;
    repeat (5) @(negedge clk);
    chk({oe_n, address_select}, {1'b1, ext_addr});
    speaker_fault_output = $urandom;
    i_host.wr(8'h05, 8'h02);
    repeat (3) @(negedge clk);
    chk({oe_n, pin_wire}, {1'b0, speaker_fault_output});
    $display("pin test done");
    end_of_test;
  end
endmodule // aacs_ctrl_status_tb

/* File: sim/aacs_host.sv */
/* Host model on the register port: single write and read strobes.
   Assumes clk is the block clock; signals change at falling edges. */
`timescale 1ns/1ps
module aacs_host (
  input wire clk,
  output reg [7:0] reg_addr,
  output reg reg_wr,
  output reg [7:0] reg_wdata,
  output reg reg_rd,
  input wire [7:0] reg_rdata
);
  // Idle port at time zero
  initial
  begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_wdata = 8'h00;
    reg_rd = 1'b0;
  end
  // One write, taken at the rising edge between two falls
  task wr(input [7:0] a, input [7:0] v);
  begin
    @(negedge clk);
    reg_addr = a;
    reg_wdata = v;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
    reg_wdata = ~v;
  end
  endtask
  // One read; data stands from the edge after the strobe
  task rd(input [7:0] a, output [7:0] v);
  begin
    @(negedge clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    v = reg_rdata;
  end
  endtask
endmodule // aacs_host
